// [src/isabr_defs.svh]
// isabr_defs.svh: address windows, strobe timing and field positions of the stacking-bus bridge
// assumes: included by bare name from src/ files; definitions only
`ifndef ISABR_DEFS_SVH
`define ISABR_DEFS_SVH

`define ISABR_IO8_BASE 32'h11E0_0000
`define ISABR_IO8_LAST 32'h11E0_03FF
`define ISABR_IO16_BASE 32'h21E0_0000
`define ISABR_IO16_LAST 32'h21E0_03FE
`define ISABR_MEM8_BASE 32'h11A0_0000
`define ISABR_MEM8_LAST 32'h11AF_FFFF
`define ISABR_MEM16_BASE 32'h21A0_0000
`define ISABR_MEM16_LAST 32'h21AF_FFFE
`define ISABR_WIN_MSB 19
`define ISABR_ISA_AW 22
`define ISABR_CLK_MHZ 250
// setup of address before strobe, least strobe width, hold after strobe, in ns
`define ISABR_SETUP_NS 100
`define ISABR_STROBE_NS 500
`define ISABR_HOLD_NS 100
`define ISABR_CYC(ns) ((((ns) * `ISABR_CLK_MHZ) + 999) / 1000)
`define ISABR_SETUP_CYC `ISABR_CYC(`ISABR_SETUP_NS)
`define ISABR_STROBE_CYC `ISABR_CYC(`ISABR_STROBE_NS)
`define ISABR_HOLD_CYC `ISABR_CYC(`ISABR_HOLD_NS)
`define ISABR_CNT_W 8
`define ISABR_IRQ_N 3

`endif

// [src/isabr_pkg.sv]
// isabr_pkg.sv: types of the stacking-bus bridge
// assumes: nothing beyond the defines header
`default_nettype none
package isabr_pkg;
    typedef enum logic [2:0]
    {
        ISABR_WIN_NONE = 3'h0,
        ISABR_WIN_IO8 = 3'h1,
        ISABR_WIN_IO16 = 3'h2,
        ISABR_WIN_MEM8 = 3'h3,
        ISABR_WIN_MEM16 = 3'h4
    } isabr_win_t;

    typedef enum logic [2:0]
    {
        ISABR_ST_IDLE = 3'h0,
        ISABR_ST_SETUP = 3'h1,
        ISABR_ST_STROBE = 3'h2,
        ISABR_ST_WAIT = 3'h3,
        ISABR_ST_HOLD = 3'h4,
        ISABR_ST_DONE = 3'h5
    } isabr_state_t;
endpackage : isabr_pkg
`default_nettype wire

// [src/isabr_decode.sv]
// isabr_decode.sv: classifies a host address into one of the four windows, or none
// assumes: address is stable while valid; purely combinational
`include "isabr_defs.svh"
`default_nettype none
module isabr_decode
    import isabr_pkg::*;
(
    input wire logic [31:0] addr_i,
    output isabr_win_t win_o,
    output logic [`ISABR_ISA_AW-1:0] isa_addr_o
);
    always_comb
    begin
        win_o = ISABR_WIN_NONE;
        // window offset goes out untranslated
        isa_addr_o = {{(`ISABR_ISA_AW - `ISABR_WIN_MSB - 1){1'b0}}, addr_i[`ISABR_WIN_MSB:0]};
        if (addr_i >= `ISABR_IO8_BASE && addr_i <= `ISABR_IO8_LAST)
        begin
            win_o = ISABR_WIN_IO8;
        end
        else if (addr_i >= `ISABR_IO16_BASE && addr_i <= `ISABR_IO16_LAST && !addr_i[0])
        begin
            win_o = ISABR_WIN_IO16;
        end
        else if (addr_i >= `ISABR_MEM8_BASE && addr_i <= `ISABR_MEM8_LAST)
        begin
            win_o = ISABR_WIN_MEM8;
        end
        else if (addr_i >= `ISABR_MEM16_BASE && addr_i <= `ISABR_MEM16_LAST && !addr_i[0])
        begin
            win_o = ISABR_WIN_MEM16;
        end
    end
endmodule : isabr_decode
`default_nettype wire

// [src/isabr_irq_sync.sv]
// isabr_irq_sync.sv: registers one stacking-bus interrupt line toward the host
// assumes: inputs already synchronous to clk_i
`default_nettype none
module isabr_irq_sync
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic irq_i,
    output logic irq_o
);
    logic irq_d;
    logic irq_q;

    always_comb
    begin
        irq_d = irq_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= irq_d;
        end
    end

    assign irq_o = irq_q;
endmodule : isabr_irq_sync
`default_nettype wire

// [src/isabr_bridge.sv]
// isabr_bridge.sv: host-to-stacking-bus bridge, four windows onto 8/16-bit I/O and memory cycles
// assumes: one 250 MHz clock, host request held until ack, bus inputs synchronous to clk_i
`include "isabr_defs.svh"
`default_nettype none
module isabr_bridge
    import isabr_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // host side
    input wire logic host_req_i,
    input wire logic host_we_i,
    input wire logic [31:0] host_addr_i,
    input wire logic [15:0] host_wdata_i,
    output logic host_ack_o,
    output logic host_err_o,
    output logic [15:0] host_rdata_o,
    output logic [`ISABR_IRQ_N-1:0] host_irq_o,
    // stacking bus side
    output logic [`ISABR_ISA_AW-1:0] bus_addr_o,
    output logic bus_bhe_n_o,
    input wire logic [7:0] bus_data_lo_i,
    output logic [7:0] bus_data_lo_o,
    output logic bus_data_lo_oe_o,
    input wire logic [7:0] bus_data_hi_i,
    output logic [7:0] bus_data_hi_o,
    output logic bus_data_hi_oe_o,
    output logic bus_ior_n_o,
    output logic bus_iow_n_o,
    output logic bus_memr_n_o,
    output logic bus_memw_n_o,
    input wire logic bus_iochrdy_i,
    input wire logic [`ISABR_IRQ_N-1:0] bus_irq_i
);
    isabr_win_t win;
    logic [`ISABR_ISA_AW-1:0] dec_addr;

    isabr_decode u_decode
    (
        .addr_i(host_addr_i),
        .win_o(win),
        .isa_addr_o(dec_addr)
    );

    // interrupt lines pass straight through, one register each
    genvar gi;
    generate
        for (gi = 0; gi < `ISABR_IRQ_N; gi++)
        begin : g_irq
            isabr_irq_sync u_irq
            (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .irq_i(bus_irq_i[gi]),
                .irq_o(host_irq_o[gi])
            );
        end
    endgenerate

    localparam logic [`ISABR_CNT_W-1:0] SETUP_CYC = `ISABR_CNT_W'(`ISABR_SETUP_CYC);
    localparam logic [`ISABR_CNT_W-1:0] STROBE_CYC = `ISABR_CNT_W'(`ISABR_STROBE_CYC);
    localparam logic [`ISABR_CNT_W-1:0] HOLD_CYC = `ISABR_CNT_W'(`ISABR_HOLD_CYC);

    isabr_state_t state_q;
    isabr_state_t state_d;
    logic [`ISABR_CNT_W-1:0] cnt_q;
    logic [`ISABR_CNT_W-1:0] cnt_d;
    logic is_io_q;
    logic is_io_d;
    logic wide_q;
    logic wide_d;
    logic we_q;
    logic we_d;
    logic [`ISABR_ISA_AW-1:0] addr_q;
    logic [`ISABR_ISA_AW-1:0] addr_d;
    logic [15:0] wdata_q;
    logic [15:0] wdata_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic ack_q;
    logic ack_d;
    logic err_q;
    logic err_d;
    logic rd_n_q;
    logic rd_n_d;
    logic wr_n_q;
    logic wr_n_d;
    logic drive_q;
    logic drive_d;
    logic bhe_n_q;
    logic bhe_n_d;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        is_io_d = is_io_q;
        wide_d = wide_q;
        we_d = we_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        ack_d = 1'b0;
        err_d = 1'b0;
        rd_n_d = rd_n_q;
        wr_n_d = wr_n_q;
        drive_d = drive_q;
        bhe_n_d = bhe_n_q;
        case (state_q)
            ISABR_ST_IDLE:
            begin
                if (host_req_i)
                begin
                    if (win == ISABR_WIN_NONE)
                    begin
                        // outside every window: no bus cycle, answered with an error
                        ack_d = 1'b1;
                        err_d = 1'b1;
                        state_d = ISABR_ST_DONE;
                    end
                    else
                    begin
                        is_io_d = (win == ISABR_WIN_IO8) || (win == ISABR_WIN_IO16);
                        wide_d = (win == ISABR_WIN_IO16) || (win == ISABR_WIN_MEM16);
                        we_d = host_we_i;
                        addr_d = dec_addr;
                        wdata_d = host_wdata_i;
                        bhe_n_d = !((win == ISABR_WIN_IO16) || (win == ISABR_WIN_MEM16));
                        drive_d = host_we_i;
                        cnt_d = SETUP_CYC;
                        state_d = ISABR_ST_SETUP;
                    end
                end
            end
            ISABR_ST_SETUP:
            begin
                if (cnt_q > `ISABR_CNT_W'(1))
                begin
                    cnt_d = cnt_q - `ISABR_CNT_W'(1);
                end
                else
                begin
                    // only one strobe of the four, chosen by space and direction
                    rd_n_d = we_q;
                    wr_n_d = !we_q;
                    cnt_d = STROBE_CYC;
                    state_d = ISABR_ST_STROBE;
                end
            end
            ISABR_ST_STROBE:
            begin
                if (cnt_q > `ISABR_CNT_W'(1))
                begin
                    cnt_d = cnt_q - `ISABR_CNT_W'(1);
                end
                else
                begin
                    state_d = ISABR_ST_WAIT;
                end
            end
            ISABR_ST_WAIT:
            begin
                // strobe held for as long as the board stretches the cycle
                // no time limit: a board that never returns ready stalls the host
                if (bus_iochrdy_i)
                begin
                    if (!we_q)
                    begin
                        rdata_d = wide_q ? {bus_data_hi_i, bus_data_lo_i} : {8'h00, bus_data_lo_i};
                    end
                    rd_n_d = 1'b1;
                    wr_n_d = 1'b1;
                    cnt_d = HOLD_CYC;
                    state_d = ISABR_ST_HOLD;
                end
            end
            ISABR_ST_HOLD:
            begin
                if (cnt_q > `ISABR_CNT_W'(1))
                begin
                    cnt_d = cnt_q - `ISABR_CNT_W'(1);
                end
                else
                begin
                    drive_d = 1'b0;
                    bhe_n_d = 1'b1;
                    ack_d = 1'b1;
                    state_d = ISABR_ST_DONE;
                end
            end
            ISABR_ST_DONE:
            begin
                // wait for the host to drop its request before the next cycle
                if (!host_req_i)
                begin
                    state_d = ISABR_ST_IDLE;
                end
            end
            default:
            begin
                state_d = ISABR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= ISABR_ST_IDLE;
            cnt_q <= '0;
            is_io_q <= 1'b0;
            wide_q <= 1'b0;
            we_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= 16'h0000;
            rdata_q <= 16'h0000;
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            drive_q <= 1'b0;
            bhe_n_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            is_io_q <= is_io_d;
            wide_q <= wide_d;
            we_q <= we_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            err_q <= err_d;
            rd_n_q <= rd_n_d;
            wr_n_q <= wr_n_d;
            drive_q <= drive_d;
            bhe_n_q <= bhe_n_d;
        end
    end

    // strobes split by space from next-state rd_n_d, wr_n_d and is_io_d, then registered, so outputs are flop-driven
    logic ior_n_q;
    logic ior_n_d;
    logic iow_n_q;
    logic iow_n_d;
    logic memr_n_q;
    logic memr_n_d;
    logic memw_n_q;
    logic memw_n_d;

    always_comb
    begin
        ior_n_d = rd_n_d | !is_io_d;
        iow_n_d = wr_n_d | !is_io_d;
        memr_n_d = rd_n_d | is_io_d;
        memw_n_d = wr_n_d | is_io_d;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            ior_n_q <= 1'b1;
            iow_n_q <= 1'b1;
            memr_n_q <= 1'b1;
            memw_n_q <= 1'b1;
        end
        else
        begin
            ior_n_q <= ior_n_d;
            iow_n_q <= iow_n_d;
            memr_n_q <= memr_n_d;
            memw_n_q <= memw_n_d;
        end
    end

    // no DMA request or acknowledge pins: those positions carry the high data byte
    assign bus_addr_o = addr_q;
    assign bus_bhe_n_o = bhe_n_q;
    assign bus_data_lo_o = wdata_q[7:0];
    assign bus_data_lo_oe_o = drive_q;
    assign bus_data_hi_o = wdata_q[15:8];
    assign bus_data_hi_oe_o = drive_q & wide_q;
    assign bus_ior_n_o = ior_n_q;
    assign bus_iow_n_o = iow_n_q;
    assign bus_memr_n_o = memr_n_q;
    assign bus_memw_n_o = memw_n_q;
    assign host_ack_o = ack_q;
    assign host_err_o = err_q;
    assign host_rdata_o = rdata_q;
endmodule : isabr_bridge
`default_nettype wire

// [tb/isabr_bridge_properties.sv]
// checker of the bridge port behaviour, bound into isabr_bridge
// assumes: defines header on the include path, one clock domain
`include "isabr_defs.svh"
`default_nettype none
module isabr_bridge_properties
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic host_ack_o,
    input wire logic host_err_o,
    input wire logic [`ISABR_IRQ_N-1:0] host_irq_o,
    input wire logic [`ISABR_ISA_AW-1:0] bus_addr_o,
    input wire logic bus_bhe_n_o,
    input wire logic bus_data_lo_oe_o,
    input wire logic bus_data_hi_oe_o,
    input wire logic bus_ior_n_o,
    input wire logic bus_iow_n_o,
    input wire logic bus_memr_n_o,
    input wire logic bus_memw_n_o,
    input wire logic bus_iochrdy_i,
    input wire logic [`ISABR_IRQ_N-1:0] bus_irq_i
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic stb;
    logic [7:0] cnt_d;
    logic [7:0] cnt_q;
    assign stb = !(bus_ior_n_o && bus_iow_n_o && bus_memr_n_o && bus_memw_n_o);
    // length of the current strobe so far
    always_comb cnt_d = stb ? cnt_q + 8'h01 : 8'h00;
    always_ff @(posedge clk_i) cnt_q <= sys_rst_i ? 8'h00 : cnt_d;
    io_only_a: assert property (!(bus_ior_n_o && bus_iow_n_o) |-> bus_memr_n_o && bus_memw_n_o)
        else $error("mem strobe in io cycle");
    mem_only_a: assert property (!(bus_memr_n_o && bus_memw_n_o) |-> bus_ior_n_o && bus_iow_n_o)
        else $error("io strobe in mem cycle");
    addr_range_a: assert property (bus_addr_o[`ISABR_ISA_AW-1:`ISABR_WIN_MSB+1] == 2'h0)
        else $error("bus address above window");
    addr_hold_a: assert property (stb && $past(stb) |-> $stable(bus_addr_o))
        else $error("address moved in strobe");
    hi_lane_a: assert property (bus_data_hi_oe_o |-> !bus_bhe_n_o)
        else $error("high byte driven in 8-bit cycle");
    rd_float_a: assert property (bus_data_lo_oe_o |-> bus_ior_n_o && bus_memr_n_o)
        else $error("data driven during read");
    err_quiet_a: assert property (host_err_o |-> host_ack_o && !stb)
        else $error("error without ack or with strobe");
    irq_pass_a: assert property (!$past(sys_rst_i) |-> host_irq_o == $past(bus_irq_i))
        else $error("interrupt not passed");
    ready_hold_a: assert property (stb && !bus_iochrdy_i |=> stb)
        else $error("strobe ended while not ready");
    strobe_width_a: assert property ($fell(stb) |-> cnt_q >= `ISABR_STROBE_CYC)
        else $error("strobe too short");
    cover property ($fell(bus_ior_n_o));
    cover property ($fell(bus_memw_n_o));
    cover property (stb && !bus_iochrdy_i);
    cover property (host_err_o);
endmodule : isabr_bridge_properties
bind isabr_bridge isabr_bridge_properties u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .host_ack_o(host_ack_o),
    .host_err_o(host_err_o), .host_irq_o(host_irq_o), .bus_addr_o(bus_addr_o), .bus_bhe_n_o(bus_bhe_n_o),
    .bus_data_lo_oe_o(bus_data_lo_oe_o), .bus_data_hi_oe_o(bus_data_hi_oe_o), .bus_ior_n_o(bus_ior_n_o),
    .bus_iow_n_o(bus_iow_n_o), .bus_memr_n_o(bus_memr_n_o), .bus_memw_n_o(bus_memw_n_o),
    .bus_iochrdy_i(bus_iochrdy_i), .bus_irq_i(bus_irq_i));
`default_nettype wire

// [tb/isabr_board_model.sv]
// behavioural stacked board: read data follows the address, ready can stretch a strobe
// assumes: strobes {ior, iow, memr, memw} and address come registered on clk_i
`default_nettype none
module isabr_board_model
(
    input wire logic clk_i,
    input wire logic [21:0] addr_i,
    input wire logic [3:0] stb_n_i,
    input wire logic stretch_i,
    input wire logic [2:0] irq_req_i,
    output logic [7:0] lo_o,
    output logic [7:0] hi_o,
    output logic rdy_o,
    output logic [2:0] irq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] age_q;
    logic rd;
    // no dma request or acknowledge lines on this board
    assign rd = !stb_n_i[3] || !stb_n_i[1];
    // released lines show the inverse so stale data cannot pass
    assign lo_o = rd ? addr_i[7:0] ^ 8'h5A : ~(addr_i[7:0] ^ 8'h5A);
    assign hi_o = rd ? addr_i[15:8] ^ 8'hC3 : ~(addr_i[15:8] ^ 8'hC3);
    // not ready across the end of the least strobe width
    assign rdy_o = !(stretch_i && age_q >= 8'h64 && age_q < 8'hA0);
    assign irq_o = irq_req_i;
    always_ff @(posedge clk_i)
    begin
        age_q <= (&stb_n_i) ? 8'h00 : age_q + 8'h01;
    end
endmodule : isabr_board_model
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench of the stacking-bus bridge with a board model on the bus side
// assumes: design sources and defines header compiled ahead of this file
`include "isabr_defs.svh"
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] S_IOR = 4'h7;
    localparam logic [3:0] S_IOW = 4'hB;
    localparam logic [3:0] S_MR = 4'hD;
    localparam logic [3:0] S_MW = 4'hE;
    int errors = 0;
    int n_compared = 0;
    logic clk_i;
    logic sys_rst_i = 1'b1;
    logic req = 1'b0;
    logic we = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [15:0] wd = 16'h0;
    logic stretch = 1'b0;
    logic [2:0] irq_req = 3'h0;
    logic ack, err, bhe_n, loe, hoe, rdy, bhe_seen, hoe_seen, loe_seen, got_err, req_q;
    logic [15:0] rd, got_rd;
    logic [2:0] h_irq, b_irq;
    logic [21:0] baddr, a_seen;
    logic [7:0] lo_i, lo_o, hi_i, hi_o, lo_seen, hi_seen, n_low;
    logic [3:0] s_seen;
    wire logic [3:0] stb_n;
    isabr_bridge u_isabr_bridge (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .host_req_i(req), .host_we_i(we),
        .host_addr_i(addr), .host_wdata_i(wd), .host_ack_o(ack), .host_err_o(err), .host_rdata_o(rd),
        .host_irq_o(h_irq), .bus_addr_o(baddr), .bus_bhe_n_o(bhe_n), .bus_data_lo_i(lo_i), .bus_data_lo_o(lo_o),
        .bus_data_lo_oe_o(loe), .bus_data_hi_i(hi_i), .bus_data_hi_o(hi_o), .bus_data_hi_oe_o(hoe),
        .bus_ior_n_o(stb_n[3]), .bus_iow_n_o(stb_n[2]), .bus_memr_n_o(stb_n[1]), .bus_memw_n_o(stb_n[0]),
        .bus_iochrdy_i(rdy), .bus_irq_i(b_irq));
    isabr_board_model u_isabr_board_model (.clk_i(clk_i), .addr_i(baddr), .stb_n_i(stb_n), .stretch_i(stretch),
        .irq_req_i(irq_req), .lo_o(lo_i), .hi_o(hi_i), .rdy_o(rdy), .irq_o(b_irq));
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // snapshot of the bus while any strobe is low, s_seen and n_low cleared at the edge that takes a request
    always @(posedge clk_i)
    begin
        req_q <= req;
        if (req && !req_q)
        begin
            s_seen <= 4'hF;
            n_low <= 8'h00;
        end
        else if (stb_n != 4'hF)
        begin
            s_seen <= stb_n;
            a_seen <= baddr;
            bhe_seen <= bhe_n;
            lo_seen <= lo_o;
            hi_seen <= hi_o;
            hoe_seen <= hoe;
            loe_seen <= loe;
            n_low <= n_low + 8'h01;
        end
    end
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic do_xfer(input logic w, input logic [31:0] a, input logic [15:0] d);
        int i;
        logic done;
        we = w;
        addr = a;
        wd = d;
        req = 1'b1;
        done = 1'b0;
        for (i = 0; i < 1000 && !done; i++)
        begin
            @(posedge clk_i);
            #1;
            done = (ack === 1'b1);
        end
        got_err = err;
        got_rd = rd;
        req = 1'b0;
        if (!done)
        begin
            errors++;
            report_and_stop();
        end
        @(posedge clk_i);
        #1;
    endtask : do_xfer
    task t_io8;
        do_xfer(1'b1, 32'h11E0_03E8, 16'h00A5);
        `CHK({s_seen, bhe_seen, a_seen}, {S_IOW, 1'b1, 22'h0003E8})
        `CHK({loe_seen, hoe_seen, lo_seen}, 10'h2A5)
        `CHK(n_low < 8'hA0, 1'b1)
        do_xfer(1'b0, 32'h11E0_03FF, 16'h0);
        `CHK({s_seen, loe_seen, got_rd}, {S_IOR, 1'b0, 16'h00A5})
    endtask : t_io8
    task t_io16;
        do_xfer(1'b1, 32'h21E0_03FE, 16'hBEEF);
        `CHK({s_seen, bhe_seen, a_seen}, {S_IOW, 1'b0, 22'h0003FE})
        `CHK({hoe_seen, hi_seen, lo_seen}, 17'h1BEEF)
        do_xfer(1'b0, 32'h21E0_0010, 16'h0);
        `CHK({s_seen, got_rd}, {S_IOR, 16'hC34A})
        do_xfer(1'b0, 32'h21E0_0011, 16'h0);
        `CHK({s_seen, got_err}, 5'h1F)
    endtask : t_io16
    task t_mem8;
        do_xfer(1'b0, 32'h11AF_FFFF, 16'h0);
        `CHK({s_seen, a_seen, got_rd}, {S_MR, 22'h0FFFFF, 16'h00A5})
        do_xfer(1'b1, 32'h11A0_0000, 16'h003C);
        `CHK({s_seen, a_seen, lo_seen}, {S_MW, 22'h0, 8'h3C})
    endtask : t_mem8
    task t_mem16;
        do_xfer(1'b1, 32'h21AF_FFFE, 16'h1234);
        `CHK({s_seen, bhe_seen, a_seen}, {S_MW, 1'b0, 22'h0FFFFE})
        `CHK({hi_seen, lo_seen}, 16'h1234)
        do_xfer(1'b0, 32'h21A0_0100, 16'h0);
        `CHK({s_seen, got_rd}, {S_MR, 16'hC25A})
    endtask : t_mem16
    task t_stretch;
        stretch = 1'b1;
        do_xfer(1'b0, 32'h11E0_0300, 16'h0);
        stretch = 1'b0;
        `CHK({n_low >= 8'hA0, got_rd}, {1'b1, 16'h005A})
    endtask : t_stretch
    task t_bad_addr;
        do_xfer(1'b1, 32'h3000_0000, 16'h0);
        `CHK({s_seen, got_err}, 5'h1F)
    endtask : t_bad_addr
    task t_irq;
        int k;
        for (k = 0; k < 8; k++)
        begin
            irq_req = k[2:0];
            @(posedge clk_i);
            #1;
            `CHK(h_irq, k[2:0])
        end
    endtask : t_irq
    initial
    begin
        repeat (10) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        t_io8();
        t_io16();
        t_mem8();
        t_mem16();
        t_stretch();
        t_bad_addr();
        t_irq();
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
